//--- core/oms_consts.vh
/*
 * Constants for the display module bring-up controller: register map,
 * command codes, their parameters and timing figures.
 * Assumes a 200 MHz system clock and an APB-attached register port.
 */
`ifndef OMS_CONSTS_VH
`define OMS_CONSTS_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define OMS_ADDR_CTRL 8'h00
`define OMS_ADDR_CMD 8'h04
`define OMS_ADDR_STATUS 8'h08
`define OMS_CTRL_UP 0
`define OMS_CTRL_DOWN 1
`define OMS_CTRL_RECOVER 2
`define OMS_CTRL_CLEAR 3
`define OMS_CLEAR_RESET 1'b1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define OMS_CLK_KHZ 200000
`define OMS_WAIT_MS 100
`define OMS_SCL_HALF_NS 100
`define OMS_CLEAR_BYTES 18432

// ----------------------------------------------------------------------
// Command codes and values
// ----------------------------------------------------------------------
`define OMS_CMD_SOFT_RESET 8'h01
`define OMS_CMD_STANDBY 8'h14
`define OMS_CMD_SCREEN_ENABLE 8'h02
`define OMS_SCREEN_OFF 8'h00
`define OMS_SCREEN_ON 8'h01
`define OMS_CMD_ANALOG 8'h0f
`define OMS_ANALOG_VAL 8'h40
`define OMS_CMD_OSC_TRIM 8'h1a
`define OMS_OSC_TRIM_VAL 8'h03
`define OMS_CMD_MEM_MODE 8'h1d
`define OMS_MEM_MODE_VAL 8'h01
`define OMS_CMD_ROW_SCAN 8'h09
`define OMS_CMD_CUR_R 8'h40
`define OMS_CMD_CUR_G 8'h41
`define OMS_CMD_CUR_B 8'h42
`define OMS_CUR_R_VAL 8'h7f
`define OMS_CUR_G_VAL 8'h65
`define OMS_CUR_B_VAL 8'h7b
`define OMS_CMD_WIN_COL_START 8'h30
`define OMS_CMD_WIN_COL_END 8'h31
`define OMS_CMD_WIN_ROW_START 8'h32
`define OMS_CMD_WIN_ROW_END 8'h33
`define OMS_WIN_START 8'h00
`define OMS_WIN_END 8'h5f
`define OMS_ZERO_BYTE 8'h00
`define OMS_INIT_LAST 5'h1d

`endif

//--- core/oms_wait_timer.v
/*
 * One-shot delay timer for the bring-up controller.
 * Assumes start is a one-cycle pulse from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module oms_wait_timer #(
  parameter integer CYCLES = 20000000,
  parameter integer W = 25
) (
  input wire clock,
  input wire nrst,
  input wire start,
  output reg done
);

  reg [W-1:0] count_reg;
  reg run_reg;

  always @(posedge clock) begin
    if (!nrst) begin
      count_reg <= {W{1'b0}};
      run_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count_reg <= {W{1'b0}};
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (count_reg == CYCLES[W-1:0] - {{(W-1){1'b0}}, 1'b1}) begin
          run_reg <= 1'b0;
          done <= 1'b1;
        end else begin
          count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // oms_wait_timer

`default_nettype wire

//--- core/oms_serial_tx.v
/*
 * Four-wire serial byte sender toward the display driver.
 * Assumes start comes while busy is low, from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module oms_serial_tx #(
  parameter integer HALF = 20
) (
  input wire clock,
  input wire nrst,
  input wire start,
  input wire [7:0] tx_byte,
  input wire tx_dc,
  output reg busy,
  output reg done,
  output reg serial_clock,
  output reg serial_data,
  output reg chip_select_low,
  output reg cmd_data_select
);

  reg [7:0] div_reg;
  reg [7:0] shift_reg;
  reg [3:0] bits_reg;
  reg phase_reg;
  wire tick;

  // Half-period enable; restarted per byte so the first low half is full
  assign tick = (div_reg == HALF[7:0] - 8'h01);

  always @(posedge clock) begin
    if (!nrst) begin
      div_reg <= 8'h00;
      shift_reg <= 8'h00;
      bits_reg <= 4'h0;
      phase_reg <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      serial_clock <= 1'b0;
      serial_data <= 1'b0;
      chip_select_low <= 1'b1;
      cmd_data_select <= 1'b0;
    end else begin
      done <= 1'b0;
      div_reg <= (tick || !busy) ? 8'h00 : div_reg + 8'h01;
      if (start && !busy) begin
        busy <= 1'b1;
        chip_select_low <= 1'b0;
        cmd_data_select <= tx_dc;
        shift_reg <= tx_byte;
        serial_data <= tx_byte[7];
        bits_reg <= 4'h0;
        phase_reg <= 1'b0;
      end else if (busy && tick) begin
        if (phase_reg) begin
          serial_clock <= 1'b0;
          phase_reg <= 1'b0;
          serial_data <= shift_reg[6];
          shift_reg <= {shift_reg[6:0], 1'b0};
          bits_reg <= bits_reg + 4'h1;
        end else if (bits_reg == 4'h8) begin
          // Select held a full half period past the last falling edge
          chip_select_low <= 1'b1;
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          serial_clock <= 1'b1;
          phase_reg <= 1'b1;
        end
      end
    end
  end

endmodule // oms_serial_tx

`default_nettype wire

//--- core/oms_init_seq.v
/*
 * Bring-up and shutdown sequencer for a passive-matrix colour display
 * module, with an APB register port for software.
 * Assumes one 200 MHz clock, synchronous active-low reset, and that the
 * logic supply switch, panel supply switch and driver pins follow the
 * outputs directly.
 */
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "oms_consts.vh"

module oms_init_seq #(
  parameter integer WAIT_CYCLES = `OMS_WAIT_MS * `OMS_CLK_KHZ,
  parameter integer CLEAR_BYTES = `OMS_CLEAR_BYTES,
  parameter [7:0] CLEAR_CMD = 8'h00
) (
  input wire clock,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg logic_supply_enable,
  output reg panel_supply_control,
  output reg chip_reset_low,
  output wire serial_clock,
  output wire serial_data,
  output wire chip_select_low,
  output wire cmd_data_select
);

  localparam integer HALF_CYC =
    (`OMS_SCL_HALF_NS * (`OMS_CLK_KHZ / 1000) + 999) / 1000;

  localparam [3:0] ST_OFF = 4'h0;
  localparam [3:0] ST_HOLD = 4'h1;
  localparam [3:0] ST_INIT = 4'h2;
  localparam [3:0] ST_CLR_CMD = 4'h3;
  localparam [3:0] ST_CLR_DATA = 4'h4;
  localparam [3:0] ST_DISP_ON = 4'h5;
  localparam [3:0] ST_VCC_WAIT = 4'h6;
  localparam [3:0] ST_ON = 4'h7;
  localparam [3:0] ST_USER = 4'h8;
  localparam [3:0] ST_DOFF = 4'h9;
  localparam [3:0] ST_DISCH = 4'ha;

  // --------------------------------------------------------------------
  // Configuration table
  // --------------------------------------------------------------------
  function [15:0] init_entry;
    input [4:0] idx;
    begin
      case (idx)
        5'h00: init_entry = {`OMS_CMD_SOFT_RESET, `OMS_ZERO_BYTE};
        5'h01: init_entry = {`OMS_CMD_STANDBY, `OMS_ZERO_BYTE};
        5'h02: init_entry = {`OMS_CMD_SCREEN_ENABLE, `OMS_SCREEN_OFF};
        5'h03: init_entry = {`OMS_CMD_ANALOG, `OMS_ANALOG_VAL};
        5'h04: init_entry = {`OMS_CMD_OSC_TRIM, `OMS_OSC_TRIM_VAL};
        5'h05: init_entry = 16'h3800;
        5'h06: init_entry = 16'h3900;
        5'h07: init_entry = 16'he000;
        5'h08: init_entry = 16'he100;
        5'h09: init_entry = 16'he500;
        5'h0a: init_entry = 16'h0d00;
        5'h0b: init_entry = {`OMS_CMD_MEM_MODE, `OMS_MEM_MODE_VAL};
        5'h0c: init_entry = {`OMS_CMD_ROW_SCAN, `OMS_ZERO_BYTE};
        5'h0d: init_entry = 16'h1300;
        5'h0e: init_entry = {`OMS_CMD_CUR_R, `OMS_CUR_R_VAL};
        5'h0f: init_entry = {`OMS_CMD_CUR_G, `OMS_CUR_G_VAL};
        5'h10: init_entry = {`OMS_CMD_CUR_B, `OMS_CUR_B_VAL};
        5'h11: init_entry = 16'h4803;
        5'h12: init_entry = 16'h1803;
        5'h13: init_entry = 16'h1600;
        5'h14: init_entry = 16'h3a03;
        5'h15: init_entry = 16'h3b03;
        5'h16: init_entry = 16'h3c02;
        5'h17: init_entry = 16'h3d09;
        5'h18: init_entry = 16'h3e09;
        5'h19: init_entry = 16'h490f;
        5'h1a: init_entry = {`OMS_CMD_WIN_COL_START, `OMS_WIN_START};
        5'h1b: init_entry = {`OMS_CMD_WIN_COL_END, `OMS_WIN_END};
        5'h1c: init_entry = {`OMS_CMD_WIN_ROW_START, `OMS_WIN_START};
        5'h1d: init_entry = {`OMS_CMD_WIN_ROW_END, `OMS_WIN_END};
        default: init_entry = 16'h0000;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg [3:0] state_reg;
  reg [1:0] step_reg;
  reg [4:0] idx_reg;
  reg [15:0] clr_cnt_reg;
  reg [15:0] user_cmd_reg;
  reg user_pend_reg;
  reg up_req_reg;
  reg down_req_reg;
  reg recover_req_reg;
  reg clear_en_reg;
  reg tx_start_reg;
  reg [7:0] tx_byte_reg;
  reg tx_dc_reg;
  reg timer_start_reg;
  reg [15:0] pair_word;
  reg [31:0] read_word;
  reg addr_hit;
  wire tx_busy;
  wire tx_done;
  wire timer_done;
  wire apb_setup;
  wire apb_write;
  wire pair_state;
  wire pair_end;

  assign apb_setup = psel && penable && !pready;
  assign apb_write = psel && penable && pready && pwrite;
  assign pair_state = (state_reg == ST_INIT) || (state_reg == ST_DISP_ON) ||
                      (state_reg == ST_USER) || (state_reg == ST_DOFF);
  assign pair_end = pair_state && (step_reg == 2'h2) && tx_done;

  // Command pair for the current sending state
  always @* begin
    pair_word = init_entry(idx_reg);
    if (state_reg == ST_DISP_ON) begin
      pair_word = {`OMS_CMD_SCREEN_ENABLE, `OMS_SCREEN_ON};
    end else if (state_reg == ST_DOFF) begin
      pair_word = {`OMS_CMD_SCREEN_ENABLE, `OMS_SCREEN_OFF};
    end else if (state_reg == ST_USER) begin
      pair_word = user_cmd_reg;
    end
  end

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  always @* begin
    read_word = 32'h00000000;
    addr_hit = 1'b1;
    if (paddr == `OMS_ADDR_CTRL) begin
      read_word[`OMS_CTRL_CLEAR] = clear_en_reg;
    end else if (paddr == `OMS_ADDR_CMD) begin
      read_word[15:0] = user_cmd_reg;
    end else if (paddr == `OMS_ADDR_STATUS) begin
      read_word[3:0] = state_reg;
      read_word[8] = tx_busy;
      read_word[9] = panel_supply_control;
      read_word[10] = chip_reset_low;
      read_word[11] = logic_supply_enable;
      read_word[12] = user_pend_reg;
      read_word[13] = (state_reg == ST_ON);
    end else begin
      addr_hit = 1'b0;
    end
  end

  // One wait cycle: answer on the second access cycle
  always @(posedge clock) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !addr_hit;
      if (apb_setup && !pwrite) begin
        prdata <= read_word;
      end
    end
  end

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always @(posedge clock) begin
    if (!nrst) begin
      state_reg <= ST_OFF;
      step_reg <= 2'h0;
      idx_reg <= 5'h00;
      clr_cnt_reg <= 16'h0000;
      user_cmd_reg <= 16'h0000;
      user_pend_reg <= 1'b0;
      up_req_reg <= 1'b0;
      down_req_reg <= 1'b0;
      recover_req_reg <= 1'b0;
      clear_en_reg <= `OMS_CLEAR_RESET;
      tx_start_reg <= 1'b0;
      tx_byte_reg <= 8'h00;
      tx_dc_reg <= 1'b0;
      timer_start_reg <= 1'b0;
      logic_supply_enable <= 1'b0;
      panel_supply_control <= 1'b0;
      chip_reset_low <= 1'b0;
    end else begin
      tx_start_reg <= 1'b0;
      timer_start_reg <= 1'b0;

      // byte pair engine: code, then one parameter
      if (pair_state) begin
        if (step_reg == 2'h0) begin
          tx_start_reg <= 1'b1;
          tx_byte_reg <= pair_word[15:8];
          tx_dc_reg <= 1'b0;
          step_reg <= 2'h1;
        end else if (step_reg == 2'h1 && tx_done) begin
          tx_start_reg <= 1'b1;
          tx_byte_reg <= pair_word[7:0];
          tx_dc_reg <= 1'b1;
          step_reg <= 2'h2;
        end else if (pair_end) begin
          step_reg <= 2'h0;
        end
      end

      case (state_reg)
        ST_OFF: begin
          if (up_req_reg) begin
            // logic on, panel supply off, reset held low
            logic_supply_enable <= 1'b1;
            panel_supply_control <= 1'b0;
            chip_reset_low <= 1'b0;
            timer_start_reg <= 1'b1;
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (timer_done) begin
            chip_reset_low <= 1'b1;
            idx_reg <= 5'h00;
            state_reg <= ST_INIT;
          end
        end
        ST_INIT: begin
          if (pair_end) begin
            if (idx_reg == `OMS_INIT_LAST) begin
              idx_reg <= 5'h00;
              state_reg <= clear_en_reg ? ST_CLR_CMD : ST_DISP_ON;
            end else begin
              idx_reg <= idx_reg + 5'h01;
            end
          end
        end
        ST_CLR_CMD: begin
          if (step_reg == 2'h0) begin
            tx_start_reg <= 1'b1;
            tx_byte_reg <= CLEAR_CMD;
            tx_dc_reg <= 1'b0;
            step_reg <= 2'h1;
          end else if (tx_done) begin
            step_reg <= 2'h0;
            clr_cnt_reg <= 16'h0000;
            state_reg <= ST_CLR_DATA;
          end
        end
        ST_CLR_DATA: begin
          if (step_reg == 2'h0) begin
            tx_start_reg <= 1'b1;
            tx_byte_reg <= `OMS_ZERO_BYTE;
            tx_dc_reg <= 1'b1;
            step_reg <= 2'h1;
          end else if (tx_done) begin
            step_reg <= 2'h0;
            if (clr_cnt_reg == CLEAR_BYTES[15:0] - 16'h0001) begin
              state_reg <= ST_DISP_ON;
            end else begin
              clr_cnt_reg <= clr_cnt_reg + 16'h0001;
            end
          end
        end
        ST_DISP_ON: begin
          if (pair_end) begin
            // panel supply after display on, then wait
            panel_supply_control <= 1'b1;
            timer_start_reg <= 1'b1;
            state_reg <= ST_VCC_WAIT;
          end
        end
        ST_VCC_WAIT: begin
          if (timer_done) begin
            state_reg <= ST_ON;
          end
        end
        ST_ON: begin
          if (down_req_reg) begin
            state_reg <= ST_DOFF;
          end else if (recover_req_reg) begin
            // recovery reruns the whole bring-up from reset
            panel_supply_control <= 1'b0;
            chip_reset_low <= 1'b0;
            timer_start_reg <= 1'b1;
            state_reg <= ST_HOLD;
          end else if (user_pend_reg) begin
            state_reg <= ST_USER;
          end
        end
        ST_USER: begin
          if (pair_end) begin
            state_reg <= ST_ON;
          end
        end
        ST_DOFF: begin
          if (pair_end) begin
            // supply off only after display off
            panel_supply_control <= 1'b0;
            timer_start_reg <= 1'b1;
            state_reg <= ST_DISCH;
          end
        end
        ST_DISCH: begin
          if (timer_done) begin
            // logic supply drops after discharge wait
            logic_supply_enable <= 1'b0;
            chip_reset_low <= 1'b0;
            state_reg <= ST_OFF;
          end
        end
        default: begin
          state_reg <= ST_OFF;
        end
      endcase

      // Requests: a new write wins over the sequencer taking one
      if (apb_write && paddr == `OMS_ADDR_CTRL) begin
        clear_en_reg <= pwdata[`OMS_CTRL_CLEAR];
      end
      if (apb_write && paddr == `OMS_ADDR_CTRL && pwdata[`OMS_CTRL_UP] &&
          state_reg == ST_OFF) begin
        up_req_reg <= 1'b1;
      end else if (state_reg == ST_OFF) begin
        up_req_reg <= 1'b0;
      end
      if (apb_write && paddr == `OMS_ADDR_CTRL &&
          pwdata[`OMS_CTRL_DOWN] && state_reg == ST_ON) begin
        down_req_reg <= 1'b1;
      end else if (state_reg == ST_ON) begin
        down_req_reg <= 1'b0;
      end
      if (apb_write && paddr == `OMS_ADDR_CTRL &&
          pwdata[`OMS_CTRL_RECOVER] && state_reg == ST_ON) begin
        recover_req_reg <= 1'b1;
      end else if (state_reg == ST_ON) begin
        recover_req_reg <= 1'b0;
      end
      // Commands written while one is pending are dropped
      if (apb_write && paddr == `OMS_ADDR_CMD && !user_pend_reg) begin
        user_cmd_reg <= pwdata[15:0];
        user_pend_reg <= 1'b1;
      end else if (state_reg == ST_USER && pair_end) begin
        user_pend_reg <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  oms_serial_tx #(
    .HALF(HALF_CYC)
  ) u_tx (
    .clock(clock),
    .nrst(nrst),
    .start(tx_start_reg),
    .tx_byte(tx_byte_reg),
    .tx_dc(tx_dc_reg),
    .busy(tx_busy),
    .done(tx_done),
    .serial_clock(serial_clock),
    .serial_data(serial_data),
    .chip_select_low(chip_select_low),
    .cmd_data_select(cmd_data_select)
  );

  oms_wait_timer #(
    .CYCLES(WAIT_CYCLES),
    .W(32)
  ) u_timer (
    .clock(clock),
    .nrst(nrst),
    .start(timer_start_reg),
    .done(timer_done)
  );

endmodule // oms_init_seq

`default_nettype wire

//--- testbench/oms_init_seq_monitor.sv
/* Checker for the bring-up controller's pin order and serial frames.
   Assumes it is bound to oms_init_seq, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module oms_init_seq_monitor #(
  parameter integer WAIT_CYCLES = 50
) (
  input wire clock,
  input wire nrst,
  input wire logic_supply_enable,
  input wire panel_supply_control,
  input wire chip_reset_low,
  input wire serial_clock,
  input wire serial_data,
  input wire chip_select_low,
  input wire cmd_data_select
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // --------
  // Byte decoder and delay counters
  // --------
  reg [7:0] shift_reg, code_reg;
  reg [3:0] edges_reg;
  reg sclk_reg, cs_reg, dc_reg, prev_dc_reg, on_reg, fresh_reg;
  reg [31:0] off_reg, hold_reg;
  wire byte_done = chip_select_low && !cs_reg;
  always @(posedge clock) begin
    if (!nrst) begin
      {shift_reg, code_reg, edges_reg} <= 20'h0;
      {sclk_reg, cs_reg, dc_reg, prev_dc_reg, on_reg, fresh_reg} <= 6'h15;
      {off_reg, hold_reg} <= 64'h0;
    end else begin
      sclk_reg <= serial_clock;
      cs_reg <= chip_select_low;
      if (!chip_select_low) dc_reg <= cmd_data_select;
      if (serial_clock && !sclk_reg) begin
        shift_reg <= {shift_reg[6:0], serial_data};
        edges_reg <= edges_reg + 4'd1;
      end
      if (byte_done) begin
        edges_reg <= 4'd0;
        prev_dc_reg <= dc_reg;
        if (!dc_reg) code_reg <= shift_reg;
      end
      if (!chip_reset_low) fresh_reg <= 1'b1;
      else if (byte_done) fresh_reg <= 1'b0;
      // Chip in reset means its screen is blank
      if (!chip_reset_low) on_reg <= 1'b0;
      else if (byte_done && dc_reg && code_reg == 8'h02) on_reg <= shift_reg[0];
      if (panel_supply_control) off_reg <= 32'd0;
      else if (off_reg < WAIT_CYCLES) off_reg <= off_reg + 32'd1;
      if (chip_reset_low || !logic_supply_enable) hold_reg <= 32'd0;
      else if (hold_reg < WAIT_CYCLES) hold_reg <= hold_reg + 32'd1;
    end
  end
  property p_hold_release;
    $rose(chip_reset_low) |-> hold_reg >= WAIT_CYCLES - 1 && !panel_supply_control;
  endproperty
  a_hold_release: assert property (p_hold_release)
    else $error("chip reset released too early");
  property p_discharge;
    $fell(logic_supply_enable) |-> !panel_supply_control && off_reg >= WAIT_CYCLES - 1;
  endproperty
  a_discharge: assert property (p_discharge)
    else $error("logic supply cut before discharge delay");
  property p_supply_up;
    $rose(panel_supply_control) |-> on_reg && chip_reset_low;
  endproperty
  a_supply_up: assert property (p_supply_up)
    else $error("panel supply raised before screen on");
  property p_supply_down;
    $fell(panel_supply_control) |-> !on_reg || !chip_reset_low;
  endproperty
  a_supply_down: assert property (p_supply_down)
    else $error("panel supply cut while screen on");
  property p_reset_no_supply;
    !chip_reset_low |-> !panel_supply_control;
  endproperty
  a_reset_no_supply: assert property (p_reset_no_supply)
    else $error("panel supply on during chip reset");
  property p_soft_reset_first;
    byte_done && fresh_reg |-> shift_reg == 8'h01 && !dc_reg;
  endproperty
  a_soft_reset_first: assert property (p_soft_reset_first)
    else $error("first byte after reset is not soft reset");
  property p_code_then_param;
    byte_done && !dc_reg |-> prev_dc_reg;
  endproperty
  a_code_then_param: assert property (p_code_then_param)
    else $error("code byte without parameter");
  property p_eight_bits;
    byte_done |-> edges_reg == 4'd8;
  endproperty
  a_eight_bits: assert property (p_eight_bits)
    else $error("frame without eight clock edges");
  property p_screen_param;
    byte_done && dc_reg && code_reg == 8'h02 |-> shift_reg[7:1] == 7'h00;
  endproperty
  a_screen_param: assert property (p_screen_param)
    else $error("bad screen enable parameter");
endmodule // oms_init_seq_monitor
bind oms_init_seq oms_init_seq_monitor #(.WAIT_CYCLES(WAIT_CYCLES)) u_mon (
  .clock, .nrst, .logic_supply_enable, .panel_supply_control,
  .chip_reset_low, .serial_clock, .serial_data, .chip_select_low,
  .cmd_data_select);
`default_nettype wire

//--- testbench/oms_chip_model.sv
/* Behavioural display driver chip on the far side of the serial link.
   Assumes the controller's clock is fed in to sample the link pins. */
`timescale 1ns/1ps
`default_nettype none
module oms_chip_model (
  input wire logic clock,
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic chip_select_low,
  input wire logic cmd_data_select,
  input wire logic chip_reset_low,
  input wire logic panel_supply_control,
  output logic byte_valid,
  output logic [7:0] byte_val,
  output logic byte_dc,
  output logic screen_on,
  output logic standby,
  output wire logic panel_high
);
  logic [7:0] shift, code, write_col_start, write_col_end, write_row_start;
  logic [7:0] write_row_end, panel_col_first, panel_col_last, panel_row_first;
  logic [7:0] panel_row_last, read_col_addr, read_row_addr, discharge_clks;
  logic [7:0] peak_delay_clks, peak_width_clks, precharge_cur, drive_cur;
  logic sclk_q, cs_q, dc_q, osc_on, scan_reverse, write_direction_hi;
  logic write_direction_lo, write_order_select;
  logic [6:0] frame_hz;
  assign panel_high = panel_supply_control;
  task load_defaults;
    {standby, screen_on, osc_on, frame_hz} = {3'b100, 7'd95};
    {write_col_start, write_row_start, panel_col_first, panel_row_first,
     read_col_addr, read_row_addr} = 48'h0;
    {write_col_end, write_row_end, panel_col_last, panel_row_last} = {4{8'h5f}};
    {write_direction_hi, write_direction_lo, write_order_select,
     scan_reverse} = 4'h0;
    {discharge_clks, peak_delay_clks, peak_width_clks, precharge_cur,
     drive_cur} = {8'd8, 8'd5, 8'd5, 16'h0};
  endtask
  initial begin
    {byte_valid, byte_val, byte_dc, code, shift, sclk_q, dc_q} = 28'h0;
    cs_q = 1'b1;
    load_defaults();
  end
  always @(posedge clock) begin
    byte_valid <= 1'b0;
    sclk_q <= serial_clock;
    cs_q <= chip_select_low;
    if (!chip_select_low) dc_q <= cmd_data_select;
    if (!chip_reset_low) load_defaults();
    else if (!chip_select_low && serial_clock && !sclk_q)
      shift = {shift[6:0], serial_data};
    else if (chip_select_low && !cs_q) begin
      byte_valid <= 1'b1;
      byte_val <= shift;
      byte_dc <= dc_q;
      if (!dc_q) code = shift;
      else if (code == 8'h02) screen_on = shift[0];
      else if (code == 8'h14) standby = shift[0];
      else if (code == 8'h01) load_defaults();
    end
  end
endmodule // oms_chip_model
`default_nettype wire

//--- testbench/tb_top.sv
/* Self-checking bench for oms_init_seq with a chip model on the link.
   Assumes short wait and clear counts to keep the run brief. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam integer WAIT = 50;
  localparam integer NCLR = 4;
  localparam logic [15:0] INIT [30] = '{16'h0100, 16'h1400, 16'h0200,
    16'h0f40, 16'h1a03, 16'h3800, 16'h3900, 16'he000, 16'he100, 16'he500,
    16'h0d00, 16'h1d01, 16'h0900, 16'h1300, 16'h407f, 16'h4165, 16'h427b,
    16'h4803, 16'h1803, 16'h1600, 16'h3a03, 16'h3b03, 16'h3c02, 16'h3d09,
    16'h3e09, 16'h490f, 16'h3000, 16'h315f, 16'h3200, 16'h335f};
  logic clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, w;
  wire [31:0] prdata;
  wire pready, pslverr, logic_supply_enable, panel_supply_control;
  wire chip_reset_low, serial_clock, serial_data, chip_select_low;
  wire cmd_data_select, byte_valid, byte_dc, screen_on, standby, panel_high;
  wire [7:0] byte_val;
  logic [8:0] exp_q[$];
  int fail_count = 0, comparisons = 0;
  always #2.5 clock = ~clock;
  oms_init_seq #(.WAIT_CYCLES(WAIT), .CLEAR_BYTES(NCLR)) DUT (.clock, .nrst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .logic_supply_enable, .panel_supply_control, .chip_reset_low,
    .serial_clock, .serial_data, .chip_select_low, .cmd_data_select);
  oms_chip_model u_chip (.clock, .serial_clock, .serial_data,
    .chip_select_low, .cmd_data_select, .chip_reset_low,
    .panel_supply_control, .byte_valid, .byte_val, .byte_dc, .screen_on,
    .standby, .panel_high);
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task check_byte(input logic [8:0] e, input logic [8:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("Error serial byte expected %h seen %h", e, g);
    end
  endtask
  task check_word(input string n, input logic [13:0] e, input logic [13:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task push(input logic [15:0] p);
    exp_q.push_back({1'b0, p[15:8]});
    exp_q.push_back({1'b1, p[7:0]});
  endtask
  task push_init(input logic clr);
    for (int i = 0; i < 30; i++) push(INIT[i]);
    if (clr) begin
      exp_q.push_back(9'h000);
      repeat (NCLR) exp_q.push_back(9'h100);
    end
    push(16'h0201);
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Drain expected bytes, then poll status until it reads v
  task settle(input logic [13:0] v);
    int n;
    n = 0;
    while (exp_q.size() > 0 && n < 90000) begin @(posedge clock); n++; end
    n = 0;
    do apb(1'b0, 8'h08, 32'h0); while (rd[13:0] !== v && ++n < 40);
    check_word("status", v, rd[13:0]);
  endtask
  // Each finished link byte takes the oldest note; a stray byte meets x
  always @(posedge clock) begin
    if (byte_valid === 1'b1)
      check_byte(exp_q.size() > 0 ? exp_q.pop_front() : 9'hxxx,
                 {byte_dc, byte_val});
  end
  initial begin
    repeat (90000) @(posedge clock);
    fail_count++;
    finish_test();
  end
  initial begin
    w = $urandom(32'haa34);
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    check_word("ctrl", 14'h8, {10'h0, rd[3], 3'h0});
    apb(1'b0, 8'h0c, 32'h0);
    check_word("slverr", 14'h1, {13'h0, err});
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b0, 8'h08, 32'h0);
    check_word("status", 14'h0, rd[13:0]);
    push_init(1'b1);
    apb(1'b1, 8'h00, 32'h9);
    settle(14'h2e07);
    check_word("chip", 14'h5, {11'h0, screen_on, standby, panel_high});
    apb(1'b1, 8'h00, 32'h1);
    w = $urandom;
    push({1'b1, w[14:0]});
    apb(1'b1, 8'h04, {16'h0, 1'b1, w[14:0]});
    settle(14'h2e07);
    push_init(1'b0);
    apb(1'b1, 8'h00, 32'h4);
    settle(14'h2e07);
    push(16'h0200);
    apb(1'b1, 8'h00, 32'h2);
    settle(14'h0000);
    check_word("chip", 14'h2, {11'h0, screen_on, standby, panel_high});
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
